/* File: smbus_map.svh */
`ifndef SMBUS_MAP_SVH
`define SMBUS_MAP_SVH

// =====================================================================
// Control byte indices
`define DIFF_OE_IDX 8'h00
`define RB_COUNT_IDX 8'h07

// =====================================================================
// Reset values and field layout
`define DIFF_OE_RESET 8'hff
`define RB_COUNT_W 5
`define RB_COUNT_RESET 5'h08
`define RB_COUNT_MSB 4

// =====================================================================
// Target addresses per strap level
`define TGT_ADDR_SEL0 7'h50
`define TGT_ADDR_SEL1 7'h51

// =====================================================================
// Request word crossing into the system domain
`define REQ_W 17
`define REQ_WR_BIT 16
`define REQ_IDX_MSB 15
`define REQ_IDX_LSB 8

// =====================================================================
// Diff output pair count
`define DIFF_NUM 8

`endif

/* File: smbus_pkg.sv */
package smbus_pkg;

    // =================================================================
    // Link engine states, Gray along the usual path
    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_RX = 3'b001,
        LK_ACK = 3'b011,
        LK_TX = 3'b010,
        LK_HACK = 3'b110
    } link_state_t;

    // =================================================================
    // Which byte of the transaction is being received
    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_INDEX = 2'b01,
        PH_COUNT = 2'b11,
        PH_WDATA = 2'b10
    } phase_t;

endpackage : smbus_pkg

/* File: bit_sync.sv */
`timescale 1ns/10ps

module bit_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Async in, synced out
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_r;

    // =================================================================
    // Two flip-flop synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end

endmodule : bit_sync

/* File: toggle_xfer.sv */
`timescale 1ns/10ps

module toggle_xfer #(
    parameter int W = 8
) (
    // Clocks and reset
    input wire logic src_clk,
    input wire logic dst_clk,
    input wire logic nrst,
    // Source side
    input wire logic send,
    input wire logic [W-1:0] din,
    // Destination side
    output logic dst_valid,
    output logic [W-1:0] dout
);

    logic tog_r;
    logic tog_nxt;
    logic [W-1:0] hold_r;
    logic [W-1:0] hold_nxt;
    logic tog_s;
    logic seen_r;
    logic seen_nxt;
    logic valid_nxt;
    logic [W-1:0] dout_nxt;

    // =================================================================
    // Source: flip toggle, hold word stable until next send
    always_comb begin
        tog_nxt = tog_r ^ send;
        hold_nxt = send ? din : hold_r;
    end

    always_ff @(posedge src_clk or negedge nrst) begin
        if (!nrst) begin
            tog_r <= 1'b0;
            hold_r <= '0;
        end else begin
            tog_r <= tog_nxt;
            hold_r <= hold_nxt;
        end
    end

    bit_sync #(.W(1)) u_tog_sync (
        .clk(dst_clk),
        .nrst(nrst),
        .d_in(tog_r),
        .q_out(tog_s)
    );

    // =================================================================
    // Destination: edge on synced toggle captures the held word
    always_comb begin
        seen_nxt = tog_s;
        valid_nxt = tog_s ^ seen_r;
        dout_nxt = valid_nxt ? hold_r : dout;
    end

    always_ff @(posedge dst_clk or negedge nrst) begin
        if (!nrst) begin
            seen_r <= 1'b0;
            dst_valid <= 1'b0;
            dout <= '0;
        end else begin
            seen_r <= seen_nxt;
            dst_valid <= valid_nxt;
            dout <= dout_nxt;
        end
    end

endmodule : toggle_xfer

/* File: smbus_block_register_access.sv */
`timescale 1ns/10ps
`include "smbus_map.svh"


module smbus_block_register_access #(
    parameter logic [6:0] ADDR_SEL0 = `TGT_ADDR_SEL0,
    parameter logic [6:0] ADDR_SEL1 = `TGT_ADDR_SEL1,
    parameter int NUM_OUT = `DIFF_NUM
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Link sampling clock
    input wire logic clk_link,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Strap
    input wire logic address_select_strap,
    // Output enable pins and diff outputs
    input wire logic [NUM_OUT-1:0] diff_oe_n,
    output logic [NUM_OUT-1:0] diff_clock_output_p,
    output logic [NUM_OUT-1:0] diff_clock_output_n,
    // Register state
    output logic [NUM_OUT-1:0] diff_output_enables,
    output logic [`RB_COUNT_W-1:0] readback_count
);
    import smbus_pkg::*;

    generate
        if (NUM_OUT != `DIFF_NUM) begin : g_chk
            $error("NUM_OUT must be 8, one enable bit per pair");
        end
    endgenerate

    // =================================================================
    // Link domain signals
    logic [1:0] pin_s;
    logic scl_s, sda_s, strap_s;
    logic scl_prev_r, sda_prev_r;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    link_state_t state_r, state_nxt;
    phase_t phase_r, phase_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic got_r, got_nxt;
    logic to_tx_r, to_tx_nxt;
    logic hack_r, hack_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic [7:0] wrem_r, wrem_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic oe_r, oe_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic [1:0] strap_cnt_r, strap_cnt_nxt;
    logic load_tx, req_send, rsp_valid;
    logic [`REQ_W-1:0] req_word;
    logic [7:0] rdata;

    // =================================================================
    // System domain signals
    logic req_valid, rsp_send, ph_r, ph_nxt;
    logic [`REQ_W-1:0] req_got;
    logic [7:0] rsp_word, rd_idx;
    logic [NUM_OUT-1:0] oe_n_s, en_r, en_nxt, run, p_nxt, n_nxt;
    logic [`RB_COUNT_W-1:0] cnt_r, cnt_nxt;

    // =================================================================
    // Pin synchronisers
    bit_sync #(.W(2)) u_pin_sync (
        .clk(clk_link), .nrst(nrst), .d_in({scl_i, sda_i}), .q_out(pin_s)
    );
    bit_sync #(.W(1)) u_strap_sync (
        .clk(clk_link), .nrst(nrst), .d_in(address_select_strap), .q_out(strap_s)
    );
    bit_sync #(.W(NUM_OUT)) u_oe_sync (
        .clk(clk_sys), .nrst(nrst), .d_in(diff_oe_n), .q_out(oe_n_s)
    );
    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];
    assign scl_rise = scl_s & ~scl_prev_r;
    assign scl_fall = ~scl_s & scl_prev_r;
    assign start_cond = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
    assign stop_cond = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

    // =================================================================
    // Domain crossings
    toggle_xfer #(.W(`REQ_W)) u_req_xfer (
        .src_clk(clk_link), .dst_clk(clk_sys), .nrst(nrst), .send(req_send), .din(req_word),
        .dst_valid(req_valid), .dout(req_got)
    );
    toggle_xfer #(.W(8)) u_rsp_xfer (
        .src_clk(clk_sys), .dst_clk(clk_link), .nrst(nrst), .send(rsp_send), .din(rsp_word),
        .dst_valid(rsp_valid), .dout(rdata)
    );

    // =================================================================
    // Link engine
    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        got_nxt = got_r;
        to_tx_nxt = to_tx_r;
        hack_nxt = hack_r;
        idx_nxt = idx_r;
        wrem_nxt = wrem_r;
        tx_nxt = tx_r;
        oe_nxt = oe_r;
        addr_nxt = addr_r;
        strap_cnt_nxt = strap_cnt_r;
        load_tx = 1'b0;
        req_send = 1'b0;
        req_word = {1'b0, idx_r, 8'h00};
        // Last capture only once the strap synchroniser has filled
        if (strap_cnt_r != 2'h3) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
            addr_nxt = strap_s ? ADDR_SEL1 : ADDR_SEL0;
        end
        if (stop_cond) begin
            state_nxt = LK_IDLE;
            oe_nxt = 1'b0;
        end else if (start_cond) begin
            state_nxt = LK_RX;
            phase_nxt = PH_ADDR;
            bit_cnt_nxt = 3'h0;
            got_nxt = 1'b0;
            oe_nxt = 1'b0;
        end else begin
            case (state_r)
                LK_IDLE: begin
                    oe_nxt = 1'b0;
                end
                LK_RX: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        bit_cnt_nxt = bit_cnt_r + 3'h1;
                        got_nxt = (bit_cnt_r == 3'h7);
                    end else if (scl_fall && got_r) begin
                        got_nxt = 1'b0;
                        state_nxt = LK_ACK;
                        oe_nxt = 1'b1;
                        to_tx_nxt = 1'b0;
                        case (phase_r)
                            PH_ADDR: begin
                                if (shift_r[7:1] != addr_r) begin
                                    state_nxt = LK_IDLE;
                                    oe_nxt = 1'b0;
                                end else if (shift_r[0]) begin
                                    to_tx_nxt = 1'b1;
                                    req_send = 1'b1;
                                    req_word = {1'b0, `RB_COUNT_IDX, 8'h00};
                                end else begin
                                    phase_nxt = PH_INDEX;
                                end
                            end
                            PH_INDEX: begin
                                idx_nxt = shift_r;
                                phase_nxt = PH_COUNT;
                            end
                            PH_COUNT: begin
                                wrem_nxt = shift_r;
                                phase_nxt = PH_WDATA;
                            end
                            PH_WDATA: begin
                                if (wrem_r == 8'h00) begin
                                    state_nxt = LK_IDLE;
                                    oe_nxt = 1'b0;
                                end else begin
                                    req_send = 1'b1;
                                    req_word = {1'b1, idx_r, shift_r};
                                    idx_nxt = idx_r + 8'h01;
                                    wrem_nxt = wrem_r - 8'h01;
                                end
                            end
                            default: begin
                                state_nxt = LK_IDLE;
                            end
                        endcase
                    end
                end
                LK_ACK: begin
                    if (scl_fall) begin
                        if (to_tx_r) begin
                            load_tx = 1'b1;
                        end else begin
                            state_nxt = LK_RX;
                            oe_nxt = 1'b0;
                            bit_cnt_nxt = 3'h0;
                        end
                    end
                end
                LK_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == 3'h7) begin
                            oe_nxt = 1'b0;
                            state_nxt = LK_HACK;
                            bit_cnt_nxt = 3'h0;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            oe_nxt = ~tx_r[6];
                            bit_cnt_nxt = bit_cnt_r + 3'h1;
                        end
                    end
                end
                LK_HACK: begin
                    if (scl_rise) begin
                        hack_nxt = ~sda_s;
                    end else if (scl_fall) begin
                        if (hack_r) begin
                            load_tx = 1'b1;
                        end else begin
                            state_nxt = LK_IDLE;
                            oe_nxt = 1'b0;
                        end
                    end
                end
                default: begin
                    state_nxt = LK_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
        if (load_tx) begin
            state_nxt = LK_TX;
            tx_nxt = rdata;
            oe_nxt = ~rdata[7];
            bit_cnt_nxt = 3'h0;
            req_send = 1'b1;
            req_word = {1'b0, idx_r, 8'h00};
            idx_nxt = idx_r + 8'h01;
        end
    end
    always_ff @(posedge clk_link or negedge nrst) begin
        if (!nrst) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
            state_r <= LK_IDLE;
            phase_r <= PH_ADDR;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            got_r <= 1'b0;
            to_tx_r <= 1'b0;
            hack_r <= 1'b0;
            idx_r <= 8'h00;
            wrem_r <= 8'h00;
            tx_r <= 8'h00;
            oe_r <= 1'b0;
            addr_r <= 7'h00;
            strap_cnt_r <= 2'h0;
        end else begin
            scl_prev_r <= scl_s;
            sda_prev_r <= sda_s;
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            got_r <= got_nxt;
            to_tx_r <= to_tx_nxt;
            hack_r <= hack_nxt;
            idx_r <= idx_nxt;
            wrem_r <= wrem_nxt;
            tx_r <= tx_nxt;
            oe_r <= oe_nxt;
            addr_r <= addr_nxt;
            strap_cnt_r <= strap_cnt_nxt;
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = oe_r;

    // =================================================================
    // Control bytes and output gating
    assign rd_idx = req_got[`REQ_IDX_MSB:`REQ_IDX_LSB];
    assign run = en_r & ~oe_n_s;

    always_comb begin
        en_nxt = en_r;
        cnt_nxt = cnt_r;
        rsp_send = 1'b0;
        rsp_word = 8'h00;
        ph_nxt = ~ph_r;
        if (req_valid && req_got[`REQ_WR_BIT]) begin
            if (rd_idx == `DIFF_OE_IDX) begin
                en_nxt = req_got[7:0];
            end else if (rd_idx == `RB_COUNT_IDX) begin
                cnt_nxt = req_got[`RB_COUNT_MSB:0];
            end
        end else if (req_valid) begin
            rsp_send = 1'b1;
            if (rd_idx == `DIFF_OE_IDX) begin
                rsp_word = en_r;
            end else if (rd_idx == `RB_COUNT_IDX) begin
                rsp_word = {3'h0, cnt_r};
            end
        end
        p_nxt = run & {NUM_OUT{ph_r}};
        n_nxt = run & {NUM_OUT{~ph_r}};
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            en_r <= `DIFF_OE_RESET;
            cnt_r <= `RB_COUNT_RESET;
            ph_r <= 1'b0;
            diff_clock_output_p <= '0;
            diff_clock_output_n <= '0;
        end else begin
            en_r <= en_nxt;
            cnt_r <= cnt_nxt;
            ph_r <= ph_nxt;
            diff_clock_output_p <= p_nxt;
            diff_clock_output_n <= n_nxt;
        end
    end

    assign diff_output_enables = en_r;
    assign readback_count = cnt_r;

endmodule : smbus_block_register_access

/* File: smbus_block_register_access_props.sv */
`timescale 1ns/10ps
`include "smbus_map.svh"

module smbus_block_register_access_chk #(
    parameter logic [6:0] ADDR_SEL0 = 7'h50,
    parameter logic [6:0] ADDR_SEL1 = 7'h51,
    parameter int NUM_OUT = 8
) (
    // Clocks and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_link,
    // Serial bus
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe,
    // Strap and outputs
    input wire logic address_select_strap,
    input wire logic [NUM_OUT-1:0] diff_clock_output_p,
    input wire logic [NUM_OUT-1:0] diff_clock_output_n,
    input wire logic [NUM_OUT-1:0] diff_output_enables,
    input wire logic [`RB_COUNT_W-1:0] readback_count
);
    // ==========================================================
    // Bus tracker
    logic scl_q, sda_q, seen_r, strap_r, match_r, rd_r, rise, start_c, stop_c;
    logic [7:0] bitn_r, sh_r, csh;
    logic [6:0] exp_a;
    assign rise = scl_i & ~scl_q;
    assign start_c = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
    assign exp_a = strap_r ? ADDR_SEL1 : ADDR_SEL0;
    assign csh = 8'(readback_count) << (bitn_r - 8'h09);
    always_ff @(posedge clk_link or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            seen_r <= 1'b0;
            strap_r <= 1'b0;
            match_r <= 1'b0;
            rd_r <= 1'b0;
            bitn_r <= 8'h00;
            sh_r <= 8'h00;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            seen_r <= 1'b1;
            if (!seen_r) strap_r <= address_select_strap;
            if (start_c) bitn_r <= 8'h00;
            else if (rise) bitn_r <= bitn_r + 8'h01;
            if (rise) sh_r <= {sh_r[6:0], sda_i};
            if (rise && bitn_r == 8'h08) begin
                match_r <= (sh_r[7:1] == exp_a);
                rd_r <= sh_r[0];
            end
        end
    end
    // ==========================================================
    // Link domain
    property p_addr_ack;
        @(posedge clk_link) disable iff (!nrst) rise && bitn_r == 8'h08 |-> !sda_i == (sh_r[7:1] == exp_a);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
    property p_idx_ack;
        @(posedge clk_link) disable iff (!nrst) rise && bitn_r == 8'h11 && match_r && !rd_r |-> !sda_i;
    endproperty
    a_idx_ack: assert property (p_idx_ack) else $error("index not acked");
    property p_cnt_ack;
        @(posedge clk_link) disable iff (!nrst) rise && bitn_r == 8'h1a && match_r && !rd_r |-> !sda_i;
    endproperty
    a_cnt_ack: assert property (p_cnt_ack) else $error("count not acked");
    property p_cnt_byte;
        @(posedge clk_link) disable iff (!nrst)
        rise && match_r && rd_r && bitn_r >= 8'h09 && bitn_r <= 8'h10 |-> sda_i == csh[7];
    endproperty
    a_cnt_byte: assert property (p_cnt_byte) else $error("count byte bit wrong");
    property p_oe_scl_low;
        @(posedge clk_link) disable iff (!nrst) $changed(sda_oe) |-> !scl_i;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with clock high");
    property p_stop_rel;
        @(posedge clk_link) disable iff (!nrst) stop_c |-> !sda_oe [*8];
    endproperty
    a_stop_rel: assert property (p_stop_rel) else $error("data held after stop");
    property p_quiet;
        @(posedge clk_link) disable iff (!nrst) !match_r && bitn_r > 8'h08 |-> !sda_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("drove for foreign address");
    // ==========================================================
    // System domain checks, then link-domain covers
    property p_rst_vals;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(nrst) |-> diff_output_enables == `DIFF_OE_RESET && readback_count == `RB_COUNT_RESET;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
    property p_legs;
        @(posedge clk_sys) disable iff (!nrst) (diff_clock_output_p & diff_clock_output_n) == '0;
    endproperty
    a_legs: assert property (p_legs) else $error("both legs high");
    property p_off_low;
        @(posedge clk_sys) disable iff (!nrst) ((diff_clock_output_p | diff_clock_output_n) & ~diff_output_enables
            & ~$past(diff_output_enables) & ~$past(diff_output_enables, 2) & ~$past(diff_output_enables, 3)) == '0;
    endproperty
    a_off_low: assert property (p_off_low) else $error("disabled pair not low");
    c_wr: cover property (@(posedge clk_link) rise && bitn_r == 8'h1a && match_r && !rd_r);
    c_rd: cover property (@(posedge clk_link) rise && bitn_r == 8'h10 && match_r && rd_r);
    c_miss: cover property (@(posedge clk_link) rise && bitn_r == 8'h08 && sh_r[7:1] != exp_a);
endmodule : smbus_block_register_access_chk

bind smbus_block_register_access smbus_block_register_access_chk #(
    .ADDR_SEL0(ADDR_SEL0), .ADDR_SEL1(ADDR_SEL1), .NUM_OUT(NUM_OUT)
) chk (
    .clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .scl_i(scl_i), .sda_i(sda_i), .sda_oe(sda_oe),
    .address_select_strap(address_select_strap), .diff_clock_output_p(diff_clock_output_p),
    .diff_clock_output_n(diff_clock_output_n), .diff_output_enables(diff_output_enables),
    .readback_count(readback_count)
);

/* File: smbus_host_model.sv */
`timescale 1ns/10ps

module smbus_host_model (
    // Clock
    input wire logic clk,
    // Bus wires
    input wire logic sda_in,
    output logic scl,
    output logic host_oe
);
    int qtr = 6;
    initial begin
        scl = 1'b1;
        host_oe = 1'b0;
    end
    // ==========================================================
    // Bus conditions
    task qw();
        repeat (qtr) @(negedge clk);
    endtask : qw
    task start();
        host_oe = 1'b0;
        qw();
        scl = 1'b1;
        qw();
        host_oe = 1'b1;
        qw();
        scl = 1'b0;
        qw();
    endtask : start
    task stop();
        host_oe = 1'b1;
        qw();
        scl = 1'b1;
        qw();
        host_oe = 1'b0;
        qw();
    endtask : stop
    task bit_io(input logic b, output logic r);
        host_oe = ~b;
        qw();
        scl = 1'b1;
        qw();
        r = sda_in;
        qw();
        scl = 1'b0;
        qw();
    endtask : bit_io
    // ==========================================================
    // Byte transfers, MSB first
    task wr_byte(input logic [7:0] d, output logic [7:0] ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = {7'h00, ~r};
    endtask : wr_byte
    task rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask : rd_byte
endmodule : smbus_host_model

/* File: smbus_block_register_access_test.sv */
`timescale 1ns/10ps
`include "smbus_map.svh"

module smbus_block_register_access_test;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic nrst = 1'b0;
    logic strap = 1'b0;
    logic [7:0] pins_n = 8'h00;
    logic scl, host_oe, sda_oe, sda_dv;
    wire sda = ~host_oe & (sda_oe ? sda_dv : 1'b1);
    logic [7:0] dp, dn, en;
    logic [4:0] rbc;
    logic [6:0] me;
    logic [7:0] wd [0:1];
    logic [7:0] rb [0:8];
    int err_total = 0;
    int n_tests = 0;

    always #20 clk_sys = ~clk_sys;
    initial begin
        #1.3;
        forever #3 clk_link = ~clk_link;
    end

    smbus_block_register_access dut (
        .clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .scl_i(scl), .sda_i(sda), .sda_o(sda_dv),
        .sda_oe(sda_oe), .address_select_strap(strap), .diff_oe_n(pins_n), .diff_clock_output_p(dp),
        .diff_clock_output_n(dn), .diff_output_enables(en), .readback_count(rbc)
    );
    smbus_host_model host (.clk(clk_sys), .sda_in(sda), .scl(scl), .host_oe(host_oe));

    // ==========================================================
    // Helpers
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask : chk
    task stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    task do_reset(input logic s);
        nrst = 1'b0;
        strap = s;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask : do_reset
    task wr(input logic [6:0] a, input logic [7:0] am, input logic [7:0] idx, input logic [7:0] n, input int m);
        logic [7:0] ack;
        host.start();
        host.wr_byte({a, 1'b0}, ack);
        chk("addr_ack", ack, am);
        if (am === 8'h01) begin
            host.wr_byte(idx, ack);
            chk("idx_ack", ack, 8'h01);
            host.wr_byte(n, ack);
            chk("cnt_ack", ack, 8'h01);
            for (int i = 0; i < m; i++) begin
                host.wr_byte(wd[i], ack);
                chk("data_ack", ack, (i < n) ? 8'h01 : 8'h00);
            end
        end
        host.stop();
    endtask : wr
    task rd(input logic [7:0] idx, input int m);
        logic [7:0] ack;
        host.start();
        host.wr_byte({me, 1'b0}, ack);
        chk("wa_ack", ack, 8'h01);
        host.wr_byte(idx, ack);
        chk("ri_ack", ack, 8'h01);
        host.start();
        host.wr_byte({me, 1'b1}, ack);
        chk("ra_ack", ack, 8'h01);
        host.rd_byte(1'b0, rb[0]);
        for (int i = 1; i <= m; i++) host.rd_byte(i == m, rb[i]);
        host.stop();
        chk("released", {7'h00, sda_oe}, 8'h00);
    endtask : rd

    // ==========================================================
    // Tests
    initial begin
        logic [7:0] t;
        do_reset(1'b0);
        me = `TGT_ADDR_SEL0;
        chk("en_rst", en, `DIFF_OE_RESET);
        chk("rbc_rst", {3'h0, rbc}, 8'h08);
        $display("done reset");
        wd[0] = 8'h5a;
        wd[1] = 8'hc3;
        wr(me, 8'h01, `DIFF_OE_IDX, 8'h01, 2);
        chk("en_wr", en, 8'h5a);
        t = dp;
        @(negedge clk_sys);
        chk("pairs_run", dp ^ t, 8'h5a);
        pins_n = 8'hf0;
        repeat (8) @(negedge clk_sys);
        chk("override", (dp | dn) & ~en, 8'h00);
        t = dp;
        @(negedge clk_sys);
        chk("pairs_mix", dp ^ t, 8'h0a);
        pins_n = 8'h00;
        $display("done write");
        rd(`DIFF_OE_IDX, 8);
        chk("cnt_byte", rb[0], 8'h08);
        chk("rd_b0", rb[1], 8'h5a);
        for (int i = 2; i < 8; i++) chk("rd_mid", rb[i], 8'h00);
        chk("rd_b7", rb[8], 8'h08);
        $display("done read");
        host.qtr = 12;
        wd[0] = 8'h77;
        wd[1] = 8'hf3;
        wr(me, 8'h01, 8'h06, 8'h02, 2);
        host.qtr = 6;
        chk("rbc_wr", {3'h0, rbc}, 8'h13);
        rd(`RB_COUNT_IDX, 1);
        chk("cnt_byte2", rb[0], 8'h13);
        chk("rd_cnt", rb[1], 8'h13);
        $display("done count");
        strap = 1'b1;
        wr(`TGT_ADDR_SEL1, 8'h00, 8'h00, 8'h00, 0);
        wr(me, 8'h01, `DIFF_OE_IDX, 8'h01, 1);
        chk("en_wr2", en, 8'h77);
        $display("done address");
        do_reset(1'b1);
        wr(`TGT_ADDR_SEL0, 8'h00, 8'h00, 8'h00, 0);
        me = `TGT_ADDR_SEL1;
        rd(`DIFF_OE_IDX, 1);
        chk("cnt_rst2", rb[0], 8'h08);
        chk("en_rst2", rb[1], 8'hff);
        $display("done strap");
        stop_test();
    end

    initial begin
        #2000000;
        err_total++;
        $display("ERROR watchdog expected end seen hang");
        stop_test();
    end
endmodule : smbus_block_register_access_test
